// >>> rtcpc_defs.svh
// Constants for the compensated real-time clock core
`ifndef RTCPC_DEFS_SVH
`define RTCPC_DEFS_SVH
`define RTCPC_CONV_PERIOD_S 7'h40
`define RTCPC_START_DELAY_S 7'h02
`define RTCPC_OSC_HALF_SEC  32768
`define RTCPC_RST_MONTH     4'h1
`define RTCPC_RST_DATE      5'h01
`define RTCPC_RST_YEAR      7'h00
`define RTCPC_RST_WDAY      3'h1
`define RTCPC_TEMP_REF      10'h064
`define RTCPC_CAP_BASE      11'h080
`define RTCPC_CAP_MAX       11'h0FF
`endif

// >>> rtcpc_pkg.sv
// Types for the compensated real-time clock core
package rtcpc_pkg;
  typedef struct packed {
    logic       pm;
    logic [4:0] hour;
    logic [5:0] min;
    logic [5:0] sec;
  } rtcpc_tod_t;
  typedef struct packed {
    logic [6:0] year;
    logic [3:0] month;
    logic [4:0] date;
    logic [2:0] wday;
    rtcpc_tod_t tod;
  } rtcpc_time_t;
  typedef enum logic [1:0] {
    CS_IDLE = 2'b00,
    CS_WAIT = 2'b01,
    CS_REQ  = 2'b10,
    CS_BUSY = 2'b11
  } rtcpc_conv_t;
endpackage : rtcpc_pkg

// >>> rtcpc_core.sv
// Clock, calendar, alarms, compensation scheduler and power control
`timescale 1ns/1ps
`include "rtcpc_defs.svh"
// Behaviour
// - Convert at power-up, then every 64 s
// - Capacitance is quadratic temperature curve plus signed aging trim
// - Apply only on temperature change or user conversion
// - Backup only when below threshold and battery
// - First battery: oscillator waits for power/address
// - Measure and correct about 2 s after start
// - Keep running and compensating while powered and disable control is clear
// - First power-up, or address write on backup, loads default date/time
// - Disable control stops oscillator, keeps registers
// - Calendar counts with correct month-end and leap
// - Hours in 24-hour or 12-hour with PM
// - Two independent time-of-day alarms
// - Shared pin gives interrupt or square wave
// - Compensated clock driven on reference output
// - Registers reached by an external bus master
// - Mode 0 square wave, mode 1 low interrupt
module rtcpc_core
  import rtcpc_pkg::*;
#(
  parameter int OSC_HALF_SEC = `RTCPC_OSC_HALF_SEC
) (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        osc_clk_in,
  input  wire logic        vcc_above_pf_in,
  input  wire logic        vcc_above_bat_in,
  input  wire logic        addr_write_in,
  input  wire logic        oscillator_disable_ctl_in,
  input  wire logic        output_mode_select_in,
  input  wire logic        hour12_mode_in,
  input  wire logic        conv_start_in,
  input  wire logic [7:0]  aging_trim_value_in,
  input  wire logic        temp_valid_in,
  input  wire logic [9:0]  temp_in,
  input  wire logic        time_wr_in,
  input  wire rtcpc_time_t time_wr_data_in,
  input  wire rtcpc_tod_t  alarm_tod_in [2],
  input  wire logic [1:0]  alarm_en_in,
  input  wire logic [1:0]  alarm_clr_in,
  output logic             use_backup_out,
  output logic             osc_run_out,
  output logic             conv_req_out,
  output logic             conv_busy_out,
  output logic [7:0]       cap_sel_out,
  output rtcpc_time_t      time_out,
  output logic [1:0]       alarm_flag_out,
  output logic             int_sqw_out,
  output logic             int_sqw_oe_n_out,
  output logic             reference_clock_output_out
);
  // ************************************************************
  // Synchronisers
  // ************************************************************
  logic pf_s1_q, pf_s2_q, pf_s3_q, bat_s1_q, bat_s2_q;
  logic sq_s1_q, sq_s2_q, sq_s3_q;
  logic sq_o_q;
  always_ff @(posedge clk_in) begin
    pf_s1_q  <= vcc_above_pf_in;
    pf_s2_q  <= pf_s1_q;
    pf_s3_q  <= pf_s2_q;
    bat_s1_q <= vcc_above_bat_in;
    bat_s2_q <= bat_s1_q;
    sq_s1_q  <= sq_o_q;
    sq_s2_q  <= sq_s1_q;
    sq_s3_q  <= sq_s2_q;
  end
  logic pf_rise, sec_tick;
  assign pf_rise  = pf_s2_q & ~pf_s3_q;
  assign sec_tick = sq_s2_q & ~sq_s3_q;

  // ************************************************************
  // Power control
  // ************************************************************
  logic use_backup_q, started_q, osc_run_q, vcc_seen_q;
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      use_backup_q <= 1'b0;
      started_q    <= 1'b0;
      osc_run_q    <= 1'b0;
      vcc_seen_q   <= 1'b0;
    end else begin
      use_backup_q <= ~pf_s2_q & ~bat_s2_q;
      if (pf_s2_q || addr_write_in) begin
        started_q <= 1'b1;
      end
      osc_run_q <= started_q & ~oscillator_disable_ctl_in;
      if (pf_s2_q) begin
        vcc_seen_q <= 1'b1;
      end
    end
  end
  logic init_ev;
  assign init_ev = (pf_rise & ~vcc_seen_q) | (addr_write_in & use_backup_q);

  // ************************************************************
  // Oscillator domain: divider and reference output
  // ************************************************************
  // Oscillator clock may stop; its logic only holds state then
  logic rst_o1_q, rst_o2_q, run_o1_q, run_o2_q, ref_q;
  logic [$clog2(OSC_HALF_SEC)-1:0] div_q;
  always_ff @(posedge osc_clk_in) begin
    rst_o1_q <= rst_in;
    rst_o2_q <= rst_o1_q;
    run_o1_q <= osc_run_q;
    run_o2_q <= run_o1_q;
  end
  always_ff @(posedge osc_clk_in) begin
    if (rst_o2_q) begin
      div_q  <= '0;
      sq_o_q <= 1'b0;
      ref_q  <= 1'b0;
    end else if (run_o2_q) begin
      ref_q <= ~ref_q;
      if (div_q == ($clog2(OSC_HALF_SEC))'(OSC_HALF_SEC - 1)) begin
        div_q  <= '0;
        sq_o_q <= ~sq_o_q;
      end else begin
        div_q <= div_q + 1'b1;
      end
    end
  end

  // ************************************************************
  // Calendar
  // ************************************************************
  function automatic logic [4:0] month_days(logic [3:0] m, logic [6:0] y);
    case (m)
      4'h2:                      month_days = (y[1:0] == 2'h0) ? 5'd29 : 5'd28;
      4'h4, 4'h6, 4'h9, 4'hB:    month_days = 5'd30;
      default:                   month_days = 5'd31;
    endcase
  endfunction : month_days

  rtcpc_time_t t_q;
  logic        day_c, tick_d_q;
  always_comb begin
    if (hour12_mode_in) begin
      day_c = (t_q.tod.hour == 5'd11) & t_q.tod.pm;
    end else begin
      day_c = (t_q.tod.hour == 5'd23);
    end
  end
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      t_q <= '{`RTCPC_RST_YEAR, `RTCPC_RST_MONTH, `RTCPC_RST_DATE, `RTCPC_RST_WDAY, '0};
    end else if (init_ev) begin
      t_q <= '{`RTCPC_RST_YEAR, `RTCPC_RST_MONTH, `RTCPC_RST_DATE, `RTCPC_RST_WDAY, '0};
    end else if (time_wr_in) begin
      t_q <= time_wr_data_in;
    end else if (sec_tick && osc_run_q) begin
      t_q.tod.sec <= (t_q.tod.sec == 6'd59) ? 6'd0 : t_q.tod.sec + 6'd1;
      if (t_q.tod.sec == 6'd59) begin
        t_q.tod.min <= (t_q.tod.min == 6'd59) ? 6'd0 : t_q.tod.min + 6'd1;
        if (t_q.tod.min == 6'd59) begin
          if (hour12_mode_in) begin
            t_q.tod.hour <= (t_q.tod.hour == 5'd12) ? 5'd1 : t_q.tod.hour + 5'd1;
            if (t_q.tod.hour == 5'd11) begin
              t_q.tod.pm <= ~t_q.tod.pm;
            end
          end else begin
            t_q.tod.hour <= day_c ? 5'd0 : t_q.tod.hour + 5'd1;
            t_q.tod.pm   <= 1'b0;
          end
          if (day_c) begin
            t_q.wday <= (t_q.wday == 3'd7) ? 3'd1 : t_q.wday + 3'd1;
            if (t_q.date >= month_days(t_q.month, t_q.year)) begin
              t_q.date <= 5'd1;
              if (t_q.month == 4'd12) begin
                t_q.month <= 4'd1;
                t_q.year  <= (t_q.year == 7'd99) ? 7'd0 : t_q.year + 7'd1;
              end else begin
                t_q.month <= t_q.month + 4'd1;
              end
            end else begin
              t_q.date <= t_q.date + 5'd1;
            end
          end
        end
      end
    end
  end
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      tick_d_q <= 1'b0;
    end else begin
      tick_d_q <= sec_tick & osc_run_q;
    end
  end

  // ************************************************************
  // Alarms
  // ************************************************************
  logic [1:0] flag_q, match;
  for (genvar i = 0; i < 2; i++) begin : g_alarm
    assign match[i] = tick_d_q && (t_q.tod == alarm_tod_in[i]);
    always_ff @(posedge clk_in) begin
      if (rst_in) begin
        flag_q[i] <= 1'b0;
      end else begin
        flag_q[i] <= match[i] | (flag_q[i] & ~alarm_clr_in[i]);
      end
    end
  end

  // ************************************************************
  // Shared pin
  // ************************************************************
  logic oe_n_q;
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      oe_n_q <= 1'b1;
    end else if (output_mode_select_in) begin
      oe_n_q <= ~|(flag_q & alarm_en_in);
    end else begin
      oe_n_q <= sq_s2_q;
    end
  end

  // ************************************************************
  // Compensation scheduler
  // ************************************************************
  rtcpc_conv_t st_q;
  logic [6:0]  cnt_q;
  logic        user_q, req_q;
  logic [9:0]  last_temp_q;
  logic [7:0]  cap_q, cap_calc;
  logic signed [23:0] dt, sum;
  always_comb begin
    dt  = $signed({14'h0000, temp_in}) - $signed({14'h0000, `RTCPC_TEMP_REF});
    sum = $signed({13'h0000, `RTCPC_CAP_BASE}) - ((dt * dt) >>> 6)
        + $signed({{16{aging_trim_value_in[7]}}, aging_trim_value_in});
    if (sum < 24'sh000000) begin
      cap_calc = 8'h00;
    end else if (sum > $signed({13'h0000, `RTCPC_CAP_MAX})) begin
      cap_calc = 8'hFF;
    end else begin
      cap_calc = sum[7:0];
    end
  end
  // Start events reach the scheduler only in idle or wait, never mid-conversion
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_q        <= CS_IDLE;
      cnt_q       <= 7'h00;
      user_q      <= 1'b0;
      req_q       <= 1'b0;
      last_temp_q <= 10'h000;
      cap_q       <= 8'(`RTCPC_CAP_BASE);
    end else begin
      req_q <= 1'b0;
      case (st_q)
        CS_IDLE, CS_WAIT: begin
          if (pf_rise || addr_write_in) begin
            st_q  <= CS_WAIT;
            cnt_q <= 7'h00;
          end else if (conv_start_in) begin
            st_q   <= CS_REQ;
            user_q <= 1'b1;
          end else if (sec_tick && osc_run_q) begin
            if (st_q == CS_WAIT && cnt_q == `RTCPC_START_DELAY_S - 7'h01) begin
              st_q <= CS_REQ;
            end else if (st_q == CS_IDLE && cnt_q == `RTCPC_CONV_PERIOD_S - 7'h01) begin
              st_q <= CS_REQ;
            end else begin
              cnt_q <= cnt_q + 7'h01;
            end
          end
        end
        CS_REQ: begin
          req_q <= 1'b1;
          st_q  <= CS_BUSY;
        end
        CS_BUSY: begin
          if (temp_valid_in) begin
            if (user_q || temp_in != last_temp_q) begin
              cap_q <= cap_calc;
            end
            last_temp_q <= temp_in;
            user_q      <= 1'b0;
            cnt_q       <= 7'h00;
            st_q        <= CS_IDLE;
          end
        end
        default: st_q <= CS_IDLE;
      endcase
    end
  end

  assign use_backup_out             = use_backup_q;
  assign osc_run_out                = osc_run_q;
  assign conv_req_out               = req_q;
  assign conv_busy_out              = st_q[1];
  assign cap_sel_out                = cap_q;
  assign time_out                   = t_q;
  assign alarm_flag_out             = flag_q;
  assign int_sqw_out                = 1'b0;
  assign int_sqw_oe_n_out           = oe_n_q;
  assign reference_clock_output_out = ref_q;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  property p_backup; !pf_s2_q && !bat_s2_q |=> use_backup_q; endproperty
  a_backup: assert property (p_backup) else $error("backup not selected");
  property p_nostart; !started_q && !pf_s2_q && !addr_write_in |=> !started_q; endproperty
  a_nostart: assert property (p_nostart) else $error("oscillator started early");
  property p_disable; oscillator_disable_ctl_in |=> !osc_run_q; endproperty
  a_disable: assert property (p_disable) else $error("oscillator not stopped");
  property p_init; init_ev |=> t_q.tod == '0 && t_q.date == 5'd1 && t_q.month == 4'd1 && t_q.wday == 3'd1; endproperty
  a_init: assert property (p_init) else $error("bad default time");
  property p_req; st_q == CS_REQ |=> req_q && st_q == CS_BUSY; endproperty
  a_req: assert property (p_req) else $error("no conversion request");
  property p_hold; st_q == CS_BUSY && !temp_valid_in |=> $stable(cap_q); endproperty
  a_hold: assert property (p_hold) else $error("trim changed mid conversion");
  property p_same; st_q == CS_BUSY && temp_valid_in && !user_q && temp_in == last_temp_q |=> $stable(cap_q); endproperty
  a_same: assert property (p_same) else $error("trim applied without change");
  property p_user; st_q == CS_BUSY && temp_valid_in && user_q |=> cap_q == $past(cap_calc); endproperty
  a_user: assert property (p_user) else $error("trim not applied");
  property p_intr; output_mode_select_in && !(|(flag_q & alarm_en_in)) |=> oe_n_q; endproperty
  a_intr: assert property (p_intr) else $error("pin driven without alarm");
  property p_sec; sec_tick && osc_run_q && !init_ev && !time_wr_in && t_q.tod.sec < 6'd59
    |=> t_q.tod.sec == $past(t_q.tod.sec) + 6'd1; endproperty
  a_sec: assert property (p_sec) else $error("seconds not advanced");
  property p_alarm; match[0] && !alarm_clr_in[0] |=> flag_q[0] ##1 (flag_q[0] || $past(alarm_clr_in[0])); endproperty
  a_alarm: assert property (p_alarm) else $error("alarm flag lost");
  property p_ref; @(posedge osc_clk_in) disable iff (rst_o2_q) run_o2_q |=> ref_q != $past(ref_q); endproperty
  a_ref: assert property (p_ref) else $error("reference clock stalled");
  c_conv: cover property (st_q == CS_BUSY && temp_valid_in);
  c_alarm: cover property (match[1] && alarm_en_in[1] && output_mode_select_in);
  c_backup: cover property (use_backup_q && addr_write_in);
endmodule : rtcpc_core

// >>> rtcpc_sensor_model.sv
// Temperature sensor model answering conversion requests
`timescale 1ns/1ps
module rtcpc_sensor_model (
  input  wire logic       clk_in,
  input  wire logic       conv_req_in,
  input  wire logic [9:0] temp_set_in,
  input  wire logic [3:0] delay_in,
  output logic            temp_valid_out,
  output logic [9:0]      temp_out
);
  // ************************************
  // Answer after a programmable delay
  // ************************************
  logic [3:0] wait_q = 4'h0;
  initial begin
    temp_valid_out = 1'b0;
    temp_out       = 10'h3FF;
  end
  // Data inverted outside the valid cycle, so a late sample shows
  always @(posedge clk_in) begin
    temp_valid_out <= 1'b0;
    temp_out       <= ~temp_set_in;
    if (conv_req_in) begin
      wait_q <= delay_in;
    end else if (wait_q == 4'h1) begin
      wait_q         <= 4'h0;
      temp_valid_out <= 1'b1;
      temp_out       <= temp_set_in;
    end else if (wait_q != 4'h0) begin
      wait_q <= wait_q - 4'h1;
    end
  end
endmodule : rtcpc_sensor_model

// >>> test_rtcpc_core.sv
// Self-checking bench for the compensated clock core
`timescale 1ns/1ps
module test_rtcpc_core;
  import rtcpc_pkg::*;
  logic        clk_in = 1'b0, rst_in = 1'b1, osc_clk = 1'b0, pf, bat, addr_wr, osc_off, mode, h12;
  logic        conv_start, temp_valid, time_wr, use_backup, osc_run, conv_req, conv_busy, int_sqw, oe_n, ref_clk;
  logic [7:0]  aging_trim_value, cap;
  logic [9:0]  temp, temp_set;
  logic [3:0]  dly;
  logic [1:0]  alarm_en, alarm_clr, flags;
  rtcpc_time_t time_wr_data, time_now;
  rtcpc_tod_t  alarm_tod [2];
  int          fails, total_checks, cycles;

  always #2 clk_in = ~clk_in;
  // Link clock at 12 ns, offset so no edge lines up with clk_in
  initial begin
    #1.3;
    forever #6 osc_clk = ~osc_clk;
  end

  rtcpc_core #(.OSC_HALF_SEC(4)) u_dut (
    .clk_in(clk_in), .rst_in(rst_in), .osc_clk_in(osc_clk), .vcc_above_pf_in(pf), .vcc_above_bat_in(bat),
    .addr_write_in(addr_wr), .oscillator_disable_ctl_in(osc_off), .output_mode_select_in(mode),
    .hour12_mode_in(h12), .conv_start_in(conv_start), .aging_trim_value_in(aging_trim_value), .temp_valid_in(temp_valid),
    .temp_in(temp), .time_wr_in(time_wr), .time_wr_data_in(time_wr_data), .alarm_tod_in(alarm_tod),
    .alarm_en_in(alarm_en), .alarm_clr_in(alarm_clr), .use_backup_out(use_backup), .osc_run_out(osc_run),
    .conv_req_out(conv_req), .conv_busy_out(conv_busy), .cap_sel_out(cap), .time_out(time_now),
    .alarm_flag_out(flags), .int_sqw_out(int_sqw), .int_sqw_oe_n_out(oe_n), .reference_clock_output_out(ref_clk));

  rtcpc_sensor_model u_sensor (.clk_in(clk_in), .conv_req_in(conv_req), .temp_set_in(temp_set),
    .delay_in(dly), .temp_valid_out(temp_valid), .temp_out(temp));

  // ************************************
  // Shared helpers
  // ************************************
  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check

  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : step

  function automatic rtcpc_time_t mk(input int y, mo, d, w, p, h, mi, s);
    return '{y[6:0], mo[3:0], d[4:0], w[2:0], '{p[0], h[4:0], mi[5:0], s[5:0]}};
  endfunction : mk

  function automatic logic [7:0] cap_of(input logic [9:0] t, input logic [7:0] a);
    int d, c;
    d = int'(t) - int'(10'h064);
    c = int'(8'h80) - (d * d) / 64 + int'($signed(a));
    return (c < 0) ? 8'h00 : (c > 255) ? 8'hFF : c[7:0];
  endfunction : cap_of

  task automatic wait_conv(input logic [7:0] exp);
    int         n;
    logic [7:0] held;
    n = 0;
    held = cap;
    while (conv_busy !== 1'b1 && n < 2000) begin
      step(1);
      n++;
    end
    while (conv_busy !== 1'b0 && n < 2100) begin
      check("cap_held", cap, held);
      step(1);
      n++;
    end
    step(2);
    check("cap_sel", cap, exp);
  endtask : wait_conv

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize

  // ************************************
  // Scenarios
  // ************************************
  task automatic t_start();
    check("osc_run_rst", osc_run, 1'b0);
    check("cap_rst", cap, 8'h80);
    check("oe_n_rst", oe_n, 1'b1);
    rst_in = 1'b0;
    step(30);
    check("osc_run", osc_run, 1'b0);
    check("use_backup", use_backup, 1'b1);
    time_wr_data = mk(33, 7, 9, 4, 0, 8, 30, 10);
    time_wr = 1'b1;
    step(1);
    time_wr = 1'b0;
    addr_wr = 1'b1;
    step(1);
    addr_wr = 1'b0;
    step(3);
    check("osc_run", osc_run, 1'b1);
    check("time_init", time_now, mk(0, 1, 1, 1, 0, 0, 0, 0));
    $display("test start done");
  endtask : t_start

  task automatic t_comp();
    temp_set = 10'h0A4;
    wait_conv(cap_of(10'h0A4, 8'h00));
    aging_trim_value = 8'h05;
    wait_conv(cap_of(10'h0A4, 8'h00));
    conv_start = 1'b1;
    step(1);
    conv_start = 1'b0;
    wait_conv(cap_of(10'h0A4, 8'h05));
    temp_set = 10'h064;
    aging_trim_value = 8'hFE;
    dly = 4'hC;
    wait_conv(cap_of(10'h064, 8'hFE));
    $display("test compensation done");
  endtask : t_comp

  task automatic t_power();
    for (int i = 0; i < 4; i++) begin
      {pf, bat} = i[1:0];
      step(6);
      check("use_backup", use_backup, !(pf || bat));
    end
    // First primary rise may start a conversion; let it settle
    step(300);
    $display("test power done");
  endtask : t_power

  task automatic t_cal();
    rtcpc_time_t a [5];
    rtcpc_time_t b [5];
    int          n;
    a = '{mk(24, 2, 28, 7, 0, 23, 59, 59), mk(23, 2, 28, 3, 0, 23, 59, 59), mk(24, 4, 30, 2, 0, 23, 59, 59),
          mk(99, 12, 31, 5, 0, 23, 59, 59), mk(24, 6, 10, 1, 0, 11, 59, 59)};
    b = '{mk(24, 2, 29, 1, 0, 0, 0, 0), mk(23, 3, 1, 4, 0, 0, 0, 0), mk(24, 5, 1, 3, 0, 0, 0, 0),
          mk(0, 1, 1, 6, 0, 0, 0, 0), mk(24, 6, 10, 1, 1, 12, 0, 0)};
    for (int i = 0; i < 5; i++) begin
      h12 = (i == 4);
      time_wr_data = a[i];
      time_wr = 1'b1;
      step(1);
      time_wr = 1'b0;
      n = 0;
      step(1);
      while (time_now === a[i] && n < 60) begin
        step(1);
        n++;
      end
      check("calendar", time_now, b[i]);
    end
    h12 = 1'b0;
    $display("test calendar done");
  endtask : t_cal

  task automatic t_alarm();
    int n, lo, hi;
    alarm_tod[0] = '{1'b0, 5'h01, 6'h02, 6'h04};
    alarm_tod[1] = '{1'b0, 5'h01, 6'h02, 6'h05};
    alarm_en = 2'b11;
    time_wr_data = mk(24, 1, 1, 1, 0, 1, 2, 3);
    time_wr = 1'b1;
    // Calendar rollovers earlier leave both flags set at midnight
    alarm_clr = 2'b11;
    step(1);
    time_wr = 1'b0;
    alarm_clr = 2'b00;
    check("alarm_pre", flags, 2'b00);
    n = 0;
    while (flags === 2'b00 && n < 60) begin
      step(1);
      n++;
    end
    check("alarm_flag", flags, 2'b01);
    step(2);
    check("int_pin", oe_n, 1'b0);
    check("int_drive", int_sqw, 1'b0);
    mode = 1'b0;
    lo = 0;
    hi = 0;
    for (int i = 0; i < 40; i++) begin
      step(1);
      lo += (oe_n === 1'b0);
      hi += (oe_n === 1'b1);
    end
    check("sqw_both", (lo > 0) && (hi > 0), 1'b1);
    mode = 1'b1;
    alarm_clr = 2'b01;
    step(1);
    alarm_clr = 2'b00;
    step(2);
    check("alarm_clr0", flags, 2'b10);
    check("int_alarm1", oe_n, 1'b0);
    alarm_clr = 2'b10;
    step(1);
    alarm_clr = 2'b00;
    step(2);
    check("alarm_clr", flags, 2'b00);
    check("int_idle", oe_n, 1'b1);
    $display("test alarm done");
  endtask : t_alarm

  task automatic t_osc();
    int          n;
    logic        r;
    rtcpc_time_t t;
    n = 0;
    for (int i = 0; i < 24; i++) begin
      r = ref_clk;
      step(1);
      n += (ref_clk !== r);
    end
    check("ref_toggles", n > 0, 1'b1);
    osc_off = 1'b1;
    step(12);
    check("osc_run", osc_run, 1'b0);
    t = time_now;
    r = ref_clk;
    step(100);
    check("time_hold", time_now, t);
    check("ref_hold", ref_clk, r);
    osc_off = 1'b0;
    step(60);
    check("osc_run", osc_run, 1'b1);
    check("time_moves", time_now !== t, 1'b1);
    $display("test oscillator done");
  endtask : t_osc

  // Ceiling well above the two 64 s waits in the compensation test
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 30000) begin
      fails++;
      summarize();
    end
  end

  initial begin
    fails = 0;
    total_checks = 0;
    cycles = 0;
    {pf, bat, addr_wr, osc_off, h12, conv_start, time_wr} = '0;
    mode = 1'b1;
    aging_trim_value = 8'h00;
    temp_set = 10'h064;
    dly = 4'h2;
    alarm_en = 2'b00;
    alarm_clr = 2'b00;
    alarm_tod[0] = '0;
    alarm_tod[1] = '0;
    time_wr_data = '0;
    // Longer than three cycles so the link side sees reset too
    step(10);
    t_start();
    t_comp();
    t_power();
    t_cal();
    t_alarm();
    t_osc();
    summarize();
  end
endmodule : test_rtcpc_core
